//--- rtl/cfg_access_defs.vh
// Constants for the configuration register access block
`ifndef CFG_ACCESS_DEFS_VH
`define CFG_ACCESS_DEFS_VH
`define IO_CFG_ADDR       16'h0CF8
`define IO_CFG_DATA       16'h0CFC
`define CFG_EN_BIT        31
`define CFG_OFFS_LO       2
`define CFG_OFFS_HI       7
`define CFG_ADDR_RST      32'h00000000
// Internal configuration dwords, index into a 64-dword space
`define CFG_IDX_ID        6'h00
`define CFG_IDX_CTRL      6'h01
`define CFG_IDX_STATUS    6'h02
`define CFG_IDX_ONCE      6'h03
`define CFG_IDX_LOCKED    6'h04
`define CFG_IDX_SCRATCH   6'h05
`define CFG_IDX_VENDOR    6'h3F
// Field layouts and reset values
`define CTRL_RST          32'h00000000
`define CTRL_RW_MASK      32'h0000FFFF
`define STATUS_W1C_MASK   32'h000000FF
`define STATUS_RST        32'h00000000
`define ONCE_RST          32'h00000000
`define LOCKED_RST        32'h00000000
`define LOCKED_LOCK_BIT   31
`define LOCKED_RW_MASK    32'h0000FFFF
`define SCRATCH_RST       32'h00000000
`define STRAP_POS         16
`define STRAP_W           2
`define ID_VALUE          32'h5A5A1234
`endif

//--- rtl/cfg_access.v
// Host I/O config address/data window with attribute-typed config registers
`timescale 1ns/10ps
`default_nettype none
`include "cfg_access_defs.vh"
module cfg_access #(
	parameter [31:0] ID_VALUE = `ID_VALUE // Arbitrary identity value
) (
	// Clock, reset, enable
	input  wire        clk_sys,
	input  wire        reset,
	input  wire        clk_en,
	input  wire        power_good,
	// Host I/O request
	input  wire        io_req,
	input  wire        io_write,
	input  wire [15:0] io_addr,
	input  wire [3:0]  io_be,
	input  wire [31:0] io_wdata,
	// Host I/O answer
	output reg         io_done,
	output reg         io_claim,
	output reg  [31:0] io_rdata,
	// Straps and hardware events
	input  wire [1:0]  strap_in,
	input  wire [7:0]  status_set,
	// Block state and control outputs
	output wire [15:0] ctrl_out,
	output wire [15:0] locked_out,
	output wire [31:0] once_out,
	output wire [31:0] cfg_addr_out
);
	// Access model as software sees it:
	// The host reaches this set only through two I/O dwords, the address
	// register and the data window behind it. A full-dword write to the
	// address register selects bus, device, function and dword; the data
	// window then reads or writes that dword, one byte lane per enable.
	// Only bus 0, device 0, function 0 is decoded here. Any other target
	// is still claimed, but reads zero and drops writes, because routing
	// to downstream buses lives outside this block.
	// Every access answers one cycle after it is taken, so the host never
	// waits on a reserved or unknown location.
	// Limitation: one access per cycle; a held request counts again.

	// Address register
	reg  [31:0] cfg_addr_reg;
	// Plain and strap-backed control dword
	reg  [31:0] ctrl_reg;
	// Hardware-set status, cleared by writing ones
	reg  [31:0] status_reg;
	// Lockable dword, bit 31 is its lock
	reg  [31:0] locked_reg;
	// Fully writable scratch dword
	reg  [31:0] scratch_reg;
	// Straps latched at power-good rise, and the edge detector for it
	reg  [1:0]  strap_reg;
	reg         pg_prev_reg;
	// Read data ahead of the answer flop
	reg  [31:0] rd_next;
	// Write-once dword, assembled from per-lane flops
	wire [31:0] once_reg;
	wire [31:0] once_rst_val;
	// Byte-lane mask from the host byte enables
	wire [31:0] byte_mask;
	// Decode terms
	wire        take;
	wire        hit_addr;
	wire        hit_data;
	wire        cfg_on;
	wire        local_fn;
	wire [5:0]  idx;
	wire        rd_cfg;
	// Write strobes, one per dword
	wire        wr_addr;
	wire        wr_cfg;
	wire        wr_ctrl;
	wire        wr_status;
	wire        wr_once;
	wire        wr_locked;
	wire        wr_scratch;
	// Field masks for the partial-write merges
	wire [31:0] ctrl_mask;
	wire [31:0] status_clr;
	wire [31:0] locked_mask;
	genvar      lane;

	// Reset value of the write-once dword, sliced per lane below
	assign once_rst_val = `ONCE_RST;

	// Decode of the two I/O ports; the address register only as a full dword
	// A narrow access to the address port is not claimed, so it cannot
	// leave a half-built address behind
	assign take     = clk_en && io_req;
	assign hit_addr = (io_addr == `IO_CFG_ADDR) && (io_be == 4'hF);
	assign hit_data = (io_addr == `IO_CFG_DATA);
	// Only bus 0 device 0 function 0 lands in this register set
	assign cfg_on   = cfg_addr_reg[`CFG_EN_BIT];
	assign local_fn = (cfg_addr_reg[23:8] == 16'h0000);
	assign idx      = cfg_addr_reg[`CFG_OFFS_HI:`CFG_OFFS_LO];
	assign rd_cfg   = hit_data && cfg_on && local_fn;

	// Write strobes; the window writes nothing while it is closed
	assign wr_addr    = take && io_write && hit_addr;
	assign wr_cfg     = take && io_write && rd_cfg;
	assign wr_ctrl    = wr_cfg && (idx == `CFG_IDX_CTRL);
	assign wr_status  = wr_cfg && (idx == `CFG_IDX_STATUS);
	assign wr_once    = wr_cfg && (idx == `CFG_IDX_ONCE);
	assign wr_locked  = wr_cfg && (idx == `CFG_IDX_LOCKED);
	assign wr_scratch = wr_cfg && (idx == `CFG_IDX_SCRATCH);

	// Only enabled lanes and defined writable bits move
	assign ctrl_mask   = byte_mask & `CTRL_RW_MASK;
	assign status_clr  = io_wdata & byte_mask & `STATUS_W1C_MASK;
	assign locked_mask = byte_mask & `LOCKED_RW_MASK;

	// Per byte lane: enable mask and the write-once flops
	// Each lane keeps its own done flag, so a byte write cannot use up
	// the single write of a neighbouring lane
	generate
		for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
			reg [7:0] lane_once_reg;
			reg       lane_done_reg;
			// Lane 0 carries the least significant byte of every dword
			assign byte_mask[lane*8 +: 8] = {8{io_be[lane]}};
			// Survives warm reset; only a power-down clears it
			always @(posedge clk_sys) begin
				if (!power_good) begin
					lane_once_reg <= once_rst_val[lane*8 +: 8];
					lane_done_reg <= 1'b0;
				end else if (wr_once && io_be[lane] && !lane_done_reg) begin
					lane_once_reg <= io_wdata[lane*8 +: 8];
					lane_done_reg <= 1'b1;
				end
			end
			assign once_reg[lane*8 +: 8] = lane_once_reg;
		end
	endgenerate

	// Read mux; unlisted offsets return zero
	// Masking by lane keeps disabled bytes at zero on the bus
	always @* begin
		rd_next = 32'h00000000;
		if (hit_addr) begin
			rd_next = cfg_addr_reg;
		end else if (rd_cfg) begin
			case (idx)
				`CFG_IDX_ID:      rd_next = ID_VALUE;
				`CFG_IDX_CTRL:    rd_next = ctrl_reg;
				`CFG_IDX_STATUS:  rd_next = status_reg;
				`CFG_IDX_ONCE:    rd_next = once_reg;
				`CFG_IDX_LOCKED:  rd_next = locked_reg;
				`CFG_IDX_SCRATCH: rd_next = scratch_reg;
				default:          rd_next = 32'h00000000;
			endcase
		end
		rd_next = rd_next & byte_mask;
	end

	// Answer: every access completes the next cycle, reserved ones too
	// Undecoded ports still answer, so a stray access never hangs the host
	always @(posedge clk_sys) begin
		if (reset) begin
			io_done  <= 1'b0;
			io_claim <= 1'b0;
			io_rdata <= 32'h00000000;
		end else if (clk_en) begin
			io_done  <= io_req;
			io_claim <= io_req && (hit_addr || hit_data);
			io_rdata <= (io_req && !io_write) ? rd_next : 32'h00000000;
		end
	end

	// Strap capture on the rising edge of power good, not under reset
	// A warm reset must keep the straps, so only power good retakes them
	always @(posedge clk_sys) begin
		if (clk_en) begin
			pg_prev_reg <= power_good;
			if (power_good && !pg_prev_reg) begin
				strap_reg <= strap_in;
			end
		end
	end

	// Address register, written whole, no merge needed
	// Reserved bits of the address are stored as written
	always @(posedge clk_sys) begin
		if (reset) begin
			cfg_addr_reg <= `CFG_ADDR_RST;
		end else if (clk_en) begin
			if (wr_addr) begin
				cfg_addr_reg <= io_wdata;
			end
		end
	end

	// Control dword: low half plain read/write, strap bits read-only
	// Strap bits follow the latch every enabled cycle out of reset, so writes never stick there
	always @(posedge clk_sys) begin
		if (reset) begin
			ctrl_reg <= `CTRL_RST;
		end else if (clk_en) begin
			if (wr_ctrl) begin
				ctrl_reg <= (ctrl_reg & ~ctrl_mask) | (io_wdata & ctrl_mask);
			end
			ctrl_reg[`STRAP_POS +: `STRAP_W] <= strap_reg;
		end
	end

	// Status dword: hardware sets, software clears with ones
	// Hardware set wins over a same-cycle clear, so no event is lost
	always @(posedge clk_sys) begin
		if (reset) begin
			status_reg <= `STATUS_RST;
		end else if (clk_en) begin
			if (wr_status) begin
				status_reg <= (status_reg & ~status_clr) | {24'h000000, status_set};
			end else begin
				status_reg <= status_reg | {24'h000000, status_set};
			end
		end
	end

	// Lockable field and its set-only lock bit
	// The lock write itself may still carry new field bytes
	always @(posedge clk_sys) begin
		if (reset) begin
			locked_reg <= `LOCKED_RST;
		end else if (clk_en) begin
			if (wr_locked && !locked_reg[`LOCKED_LOCK_BIT]) begin
				locked_reg <= (locked_reg & ~locked_mask) | (io_wdata & locked_mask);
				if (io_be[3] && io_wdata[`LOCKED_LOCK_BIT]) begin
					locked_reg[`LOCKED_LOCK_BIT] <= 1'b1;
				end
			end
		end
	end

	// Scratch dword, every bit plain read/write
	always @(posedge clk_sys) begin
		if (reset) begin
			scratch_reg <= `SCRATCH_RST;
		end else if (clk_en) begin
			if (wr_scratch) begin
				scratch_reg <= (scratch_reg & ~byte_mask) | (io_wdata & byte_mask);
			end
		end
	end

	// Register views for the rest of the device

	assign ctrl_out     = ctrl_reg[15:0];
	assign locked_out   = locked_reg[15:0];
	assign once_out     = once_reg;
	assign cfg_addr_out = cfg_addr_reg;
endmodule
`default_nettype wire

//--- verif/cfg_access_monitor.sv
// Port-level checks of the config access block
`timescale 1ns/10ps
`default_nettype none
module cfg_access_monitor (
	input wire        clk_sys, reset, clk_en, io_req, io_write, io_done, io_claim,
	input wire [15:0] io_addr,
	input wire [3:0]  io_be,
	input wire [31:0] io_wdata, io_rdata, cfg_addr_out
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// Request decode shared by the properties
	wire go = io_req && clk_en;
	wire adr = go && io_addr == 16'h0CF8;
	wire full = adr && io_be == 4'hF;
	property p_answer; go |=> io_done; endproperty
	a_answer: assert property (p_answer) else $error("no answer");
	property p_quiet; !go |=> !io_done; endproperty
	a_quiet: assert property (p_quiet) else $error("stray answer");
	property p_claim; go && io_addr == 16'h0CFC |=> io_claim; endproperty
	a_claim: assert property (p_claim) else $error("data not claimed");
	property p_nclaim; adr && io_be != 4'hF |=> !io_claim; endproperty
	a_nclaim: assert property (p_nclaim) else $error("narrow claimed");
	property p_nkeep; adr && io_be != 4'hF |=> $stable(cfg_addr_out); endproperty
	a_nkeep: assert property (p_nkeep) else $error("narrow wrote");
	property p_awr; full && io_write |=> cfg_addr_out == $past(io_wdata); endproperty
	a_awr: assert property (p_awr) else $error("address not written");
	property p_ard; full && !io_write |=> io_rdata == $past(cfg_addr_out); endproperty
	a_ard: assert property (p_ard) else $error("address readback");
	property p_off;
		go && !io_write && io_addr == 16'h0CFC && !cfg_addr_out[31] |=> io_rdata == 32'h0;
	endproperty
	a_off: assert property (p_off) else $error("window open");
	c_full: cover property (full && io_write);
	c_narrow: cover property (adr && io_be != 4'hF);
	c_data: cover property (go && io_addr == 16'h0CFC);
endmodule
bind cfg_access cfg_access_monitor i_cfg_access_monitor (.*);
`default_nettype wire

//--- verif/host_model.sv
// Host side issuing I/O accesses
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input wire         clk_sys, io_done,
	input wire  [31:0] io_rdata,
	output logic       io_req = 1'b0, io_write = 1'b0,
	output logic [15:0] io_addr = 16'h0CF8,
	output logic [3:0]  io_be = 4'hF,
	output logic [31:0] io_wdata = 32'h0
);
	// One-cycle request, answer sampled mid-cycle after the taking edge
	task automatic xfer(input logic w, input logic [15:0] a, input logic [3:0] b,
		input logic [31:0] d, output logic [31:0] r, output logic ok);
		@(posedge clk_sys);
		io_req <= 1'b1;
		io_write <= w;
		io_addr <= a; // Mechanism one ports only
		io_be <= b;
		io_wdata <= d; // Full value to address register, no merge
		@(posedge clk_sys);
		io_req <= 1'b0;
		io_wdata <= ~d; // Released data does not keep its value
		@(negedge clk_sys);
		ok = io_done;
		r = io_rdata;
	endtask
endmodule
`default_nettype wire

//--- verif/tb_config_register_access_rules.sv
// Self-checking bench for the config access block
`timescale 1ns/10ps
`default_nettype none
module tb_config_register_access_rules;
	logic        clk_sys = 0, reset = 1, clk_en = 1, power_good = 0;
	logic [1:0]  strap_in = 2'h2;
	logic [7:0]  status_set = 8'h00;
	logic        io_req, io_write, io_done, io_claim;
	logic [15:0] io_addr, ctrl_out, locked_out;
	logic [3:0]  io_be;
	logic [31:0] io_wdata, io_rdata, once_out, cfg_addr_out, r;
	logic        ok;
	logic [71:0] rows [0:25];
	int          error_cnt = 0, samples_checked = 0;
	initial forever #25 clk_sys = ~clk_sys;
	cfg_access i_cfg_access (.*);
	host_model i_host_model (.*);
	task automatic chk(input string n, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic give_verdict;
		$display("checked %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Row: {w,data window} nibble, byte enables, write data, expected read data
	task automatic acc(input logic [71:0] x);
		logic ok;
		i_host_model.xfer(x[69], x[68] ? 16'h0CFC : 16'h0CF8, x[67:64], x[63:32], r, ok);
		chk("done", {31'h0, ok}, 32'h1);
		chk("rdata", r, x[31:0]);
	endtask
	// Vendor index never written, straps latched before reset release
	initial begin
		rows = '{72'h2_F_80000014_00000000, 72'h3_F_11223344_00000000,
			72'h3_2_0000AA00_00000000, 72'h1_1_00000000_00000044,
			72'h1_F_00000000_1122AA44, 72'h2_1_000000FF_00000000,
			72'h0_F_00000000_80000014, 72'h2_F_80000000_00000000,
			72'h3_F_FFFFFFFF_00000000, 72'h1_F_00000000_5A5A1234,
			72'h2_F_80000020_00000000, 72'h1_C_00000000_00000000,
			72'h2_F_00000014_00000000, 72'h1_F_00000000_00000000,
			72'h2_F_80000010_00000000, 72'h3_F_0000ABCD_00000000,
			72'h3_8_80000000_00000000, 72'h3_F_0000FFFF_00000000,
			72'h1_F_00000000_8000ABCD, 72'h2_F_8000000C_00000000,
			72'h3_F_12345678_00000000, 72'h3_F_FFFFFFFF_00000000,
			72'h1_F_00000000_12345678, 72'h2_F_80000004_00000000,
			72'h1_F_00000000_00020000, 72'h2_F_80000008_00000000};
		repeat (3) @(posedge clk_sys);
		power_good <= 1'b1;
		repeat (7) @(posedge clk_sys);
		reset <= 1'b0;
		@(negedge clk_sys) chk("ctrl", {16'h0, ctrl_out}, 32'h0);
		foreach (rows[i]) acc(rows[i]);
		chk("locked", {16'h0, locked_out}, 32'h0000ABCD);
		// Hardware sets status, then a one clears only its bit
		@(posedge clk_sys) status_set <= 8'h81;
		@(posedge clk_sys) status_set <= 8'h00;
		acc(72'h1_F_00000000_00000081);
		acc(72'h3_F_00000001_00000000);
		acc(72'h1_F_00000000_00000080);
		// Set held across a clear: the set wins
		@(posedge clk_sys) status_set <= 8'h01;
		acc(72'h3_F_00000001_00000000);
		acc(72'h1_F_00000000_00000081);
		@(posedge clk_sys) status_set <= 8'h00;
		acc(72'h3_F_00000081_00000000);
		acc(72'h1_F_00000000_00000000);
		// Read-merge-write of control, reserved strap bits written back
		acc(72'h2_F_80000004_00000000);
		acc(72'h1_F_00000000_00020000);
		acc({4'h3, 4'hF, ((r & 32'hFFFFFF00) | 32'h0000005A), 32'h00000000});
		chk("ctrl", {16'h0, ctrl_out}, 32'h0000005A);
		// Enable low: a request is neither answered nor applied
		@(posedge clk_sys) clk_en <= 1'b0;
		i_host_model.xfer(1'b1, 16'h0CF8, 4'hF, 32'h80000014, r, ok);
		chk("frozen done", {31'h0, ok}, 32'h0);
		chk("frozen addr", cfg_addr_out, 32'h80000004);
		@(posedge clk_sys) clk_en <= 1'b1;
		// Mid-run reset: defaults back, write-once survives until power-down
		@(posedge clk_sys) reset <= 1'b1;
		@(posedge clk_sys) reset <= 1'b0;
		@(negedge clk_sys) chk("addr", cfg_addr_out, 32'h0);
		chk("once", once_out, 32'h12345678);
		give_verdict();
	end
endmodule
`default_nettype wire
